/* common/dac_routing_popreduce_regs.svh */
// register map, field codes and timing constants of the routing and pop-reduction bank
`ifndef DAC_ROUTING_POPREDUCE_REGS_SVH
`define DAC_ROUTING_POPREDUCE_REGS_SVH

// ==========================================================
// register offsets and reset values
`define ROUTING_CTRL_ADDR   8'h29
`define POP_CTRL_ADDR       8'h2A
`define ROUTING_CTRL_RST    8'h00
`define POP_CTRL_RST        8'h00
`define UNMAPPED_RDATA      8'h00

// ==========================================================
// routing path codes
`define PATH_DEFAULT        2'h0
`define PATH_LINEOUT        2'h1
`define PATH_HIGHPOWER      2'h2

// ==========================================================
// volume-linking codes
`define LINK_LEFT_FOLLOWS   2'h1
`define LINK_RIGHT_FOLLOWS  2'h2

// ==========================================================
// timing
`define CLK_CYC_PER_US      100
`define US_PER_MS           1000
`define DLY_T1_US           10
`define DLY_T2_US           100
`define DLY_T3_MS           1
`define DLY_T4_MS           10
`define DLY_T5_MS           50
`define DLY_T6_MS           50
`define DLY_T7_MS           200
`define DLY_T8_MS           400
`define DLY_T9_MS           800
`define DLY_T10_MS          2000
`define DLY_T11_MS          4000
`define DLY_CODE_LAST       4'hB
`define STEP_T1_MS          1
`define STEP_T2_MS          2
`define STEP_T3_MS          4

`endif

/* common/dac_routing_popreduce_pkg.sv */
// types shared by the routing and pop-reduction bank
package dac_routing_popreduce_pkg;

    // ==========================================================
    // register images
    typedef struct packed {
        logic [1:0] left_route;
        logic [1:0] right_route;
        logic [1:0] rsvd;
        logic [1:0] vol_link;
    } routing_ctrl_t;

    typedef struct packed {
        logic [3:0] on_delay;
        logic [1:0] ramp_step;
        logic       weak_cm_bandgap;
        logic       rsvd;
    } pop_ctrl_t;

    typedef struct packed {
        logic       mute;
        logic [6:0] atten;
    } dac_vol_t;

    typedef struct packed {
        logic default_path;
        logic lineout_path;
        logic highpower_path;
    } path_sel_t;

    // ==========================================================
    // driver power-up sequencer
    typedef enum logic [1:0] {
        DRV_OFF,
        DRV_DELAY,
        DRV_RAMP,
        DRV_ON
    } drv_state_t;

endpackage : dac_routing_popreduce_pkg

/* core/dac_routing_popreduce_regs.sv */
// routing and pop-reduction control bank with driver power-up sequencer
`timescale 1ns/1ps
`include "dac_routing_popreduce_regs.svh"
module dac_routing_popreduce_regs #(
    parameter int unsigned DLY_CYC [12] = '{
        0,
        `DLY_T1_US * `CLK_CYC_PER_US,
        `DLY_T2_US * `CLK_CYC_PER_US,
        `DLY_T3_MS * `US_PER_MS * `CLK_CYC_PER_US,
        `DLY_T4_MS * `US_PER_MS * `CLK_CYC_PER_US,
        `DLY_T5_MS * `US_PER_MS * `CLK_CYC_PER_US,
        `DLY_T6_MS * `US_PER_MS * `CLK_CYC_PER_US,
        `DLY_T7_MS * `US_PER_MS * `CLK_CYC_PER_US,
        `DLY_T8_MS * `US_PER_MS * `CLK_CYC_PER_US,
        `DLY_T9_MS * `US_PER_MS * `CLK_CYC_PER_US,
        `DLY_T10_MS * `US_PER_MS * `CLK_CYC_PER_US,
        `DLY_T11_MS * `US_PER_MS * `CLK_CYC_PER_US},
    parameter int unsigned STEP_CYC [4] = '{
        0,
        `STEP_T1_MS * `US_PER_MS * `CLK_CYC_PER_US,
        `STEP_T2_MS * `US_PER_MS * `CLK_CYC_PER_US,
        `STEP_T3_MS * `US_PER_MS * `CLK_CYC_PER_US},
    parameter int unsigned RAMP_STEPS = 8,
    parameter int unsigned LVL_W      = $clog2(RAMP_STEPS + 1)
) (
    input  wire logic                               clk,
    input  wire logic                               rst,
    input  wire logic                               wr_en,
    input  wire logic                               rd_en,
    input  wire logic [7:0]                         addr,
    input  wire logic [7:0]                         wdata,
    output logic      [7:0]                         rdata,
    input  wire dac_routing_popreduce_pkg::dac_vol_t left_vol_reg,
    input  wire dac_routing_popreduce_pkg::dac_vol_t right_vol_reg,
    output dac_routing_popreduce_pkg::dac_vol_t     left_vol_eff,
    output dac_routing_popreduce_pkg::dac_vol_t     right_vol_eff,
    output dac_routing_popreduce_pkg::path_sel_t    left_path,
    output dac_routing_popreduce_pkg::path_sel_t    right_path,
    output logic                                    weak_cm_bandgap,
    input  wire logic                               drv_power_req,
    output logic                                    drv_enable,
    output logic      [LVL_W-1:0]                   drv_ramp_level,
    output logic                                    drv_ready
);

    localparam logic [LVL_W-1:0] LVL_MAX = LVL_W'(RAMP_STEPS);

    // ==========================================================
    // register file
    dac_routing_popreduce_pkg::routing_ctrl_t routing_ff, nxt_routing;
    dac_routing_popreduce_pkg::pop_ctrl_t     pop_ff, nxt_pop;
    logic [7:0]                               rdata_ff, nxt_rdata;

    always_comb begin
        nxt_routing = routing_ff;
        nxt_pop     = pop_ff;
        nxt_rdata   = rdata_ff;
        // reserved bits are stored as written; software keeps them zero
        if (wr_en && addr == `ROUTING_CTRL_ADDR) begin
            nxt_routing = wdata;
        end
        if (wr_en && addr == `POP_CTRL_ADDR) begin
            nxt_pop = wdata;
        end
        if (rd_en) begin
            case (addr)
                `ROUTING_CTRL_ADDR: nxt_rdata = routing_ff;
                `POP_CTRL_ADDR:     nxt_rdata = pop_ff;
                default:            nxt_rdata = `UNMAPPED_RDATA;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            routing_ff <= `ROUTING_CTRL_RST;
            pop_ff     <= `POP_CTRL_RST;
            rdata_ff   <= `UNMAPPED_RDATA;
        end else begin
            routing_ff <= nxt_routing;
            pop_ff     <= nxt_pop;
            rdata_ff   <= nxt_rdata;
        end
    end

    assign rdata = rdata_ff;

    // ==========================================================
    // routing and volume linking
    dac_routing_popreduce_pkg::path_sel_t left_path_ff, nxt_left_path;
    dac_routing_popreduce_pkg::path_sel_t right_path_ff, nxt_right_path;
    dac_routing_popreduce_pkg::dac_vol_t  left_vol_ff, nxt_left_vol;
    dac_routing_popreduce_pkg::dac_vol_t  right_vol_ff, nxt_right_vol;
    logic                                 cm_ff, nxt_cm;

    function automatic dac_routing_popreduce_pkg::path_sel_t route_dec(input logic [1:0] code);
        dac_routing_popreduce_pkg::path_sel_t p;
        p                = '0;
        // code 11 is reserved: no path at all rather than a guess
        p.default_path   = (code == `PATH_DEFAULT);
        p.lineout_path   = (code == `PATH_LINEOUT);
        p.highpower_path = (code == `PATH_HIGHPOWER);
        return p;
    endfunction : route_dec

    always_comb begin
        nxt_left_path  = route_dec(routing_ff.left_route);
        nxt_right_path = route_dec(routing_ff.right_route);
        nxt_left_vol   = left_vol_reg;
        nxt_right_vol  = right_vol_reg;
        if (routing_ff.vol_link == `LINK_LEFT_FOLLOWS) begin
            nxt_left_vol = right_vol_reg;
        end
        if (routing_ff.vol_link == `LINK_RIGHT_FOLLOWS) begin
            nxt_right_vol = left_vol_reg;
        end
        nxt_cm = pop_ff.weak_cm_bandgap;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_path_ff  <= '0;
            right_path_ff <= '0;
            left_vol_ff   <= '0;
            right_vol_ff  <= '0;
            cm_ff         <= 1'b0;
        end else begin
            left_path_ff  <= nxt_left_path;
            right_path_ff <= nxt_right_path;
            left_vol_ff   <= nxt_left_vol;
            right_vol_ff  <= nxt_right_vol;
            cm_ff         <= nxt_cm;
        end
    end

    assign left_path       = left_path_ff;
    assign right_path      = right_path_ff;
    assign left_vol_eff    = left_vol_ff;
    assign right_vol_eff   = right_vol_ff;
    assign weak_cm_bandgap = cm_ff;

    // ==========================================================
    // driver power-up sequencer
    dac_routing_popreduce_pkg::drv_state_t state_ff, nxt_state;
    logic [31:0]                           cnt_ff, nxt_cnt;
    logic [LVL_W-1:0]                      lvl_ff, nxt_lvl;
    logic                                  en_ff, nxt_en;
    logic                                  rdy_ff, nxt_rdy;
    logic [31:0]                           dly_sel;
    logic [31:0]                           step_sel;

    // reserved delay codes fall back to the longest delay
    always_comb begin
        if (pop_ff.on_delay > `DLY_CODE_LAST) begin
            dly_sel = DLY_CYC[`DLY_CODE_LAST];
        end else begin
            dly_sel = DLY_CYC[pop_ff.on_delay];
        end
        step_sel = STEP_CYC[pop_ff.ramp_step];
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_lvl   = lvl_ff;
        case (state_ff)
            dac_routing_popreduce_pkg::DRV_OFF: begin
                nxt_lvl = '0;
                if (drv_power_req) begin
                    nxt_state = dac_routing_popreduce_pkg::DRV_DELAY;
                    nxt_cnt   = dly_sel;
                end
            end
            dac_routing_popreduce_pkg::DRV_DELAY: begin
                if (cnt_ff == '0) begin
                    nxt_state = dac_routing_popreduce_pkg::DRV_RAMP;
                    nxt_cnt   = step_sel;
                end else begin
                    nxt_cnt = cnt_ff - 32'h1;
                end
            end
            dac_routing_popreduce_pkg::DRV_RAMP: begin
                if (cnt_ff == '0) begin
                    nxt_lvl = lvl_ff + LVL_W'(1);
                    nxt_cnt = step_sel;
                    if (lvl_ff + LVL_W'(1) == LVL_MAX) begin
                        nxt_state = dac_routing_popreduce_pkg::DRV_ON;
                    end
                end else begin
                    nxt_cnt = cnt_ff - 32'h1;
                end
            end
            dac_routing_popreduce_pkg::DRV_ON: begin
                nxt_lvl = LVL_MAX;
            end
            default: begin
                nxt_state = dac_routing_popreduce_pkg::DRV_OFF;
            end
        endcase
        // dropping the request powers down at once, mid-sequence too
        if (!drv_power_req) begin
            nxt_state = dac_routing_popreduce_pkg::DRV_OFF;
            nxt_lvl   = '0;
            nxt_cnt   = '0;
        end
        nxt_en  = (nxt_state == dac_routing_popreduce_pkg::DRV_RAMP) ||
                  (nxt_state == dac_routing_popreduce_pkg::DRV_ON);
        nxt_rdy = (nxt_state == dac_routing_popreduce_pkg::DRV_ON);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= dac_routing_popreduce_pkg::DRV_OFF;
            cnt_ff   <= '0;
            lvl_ff   <= '0;
            en_ff    <= 1'b0;
            rdy_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            lvl_ff   <= nxt_lvl;
            en_ff    <= nxt_en;
            rdy_ff   <= nxt_rdy;
        end
    end

    assign drv_enable     = en_ff;
    assign drv_ramp_level = lvl_ff;
    assign drv_ready      = rdy_ff;

    // ==========================================================
    // assertions
    property p_left_route;
        @(posedge clk) disable iff (rst)
        wr_en && addr == `ROUTING_CTRL_ADDR && wdata[7:6] == `PATH_HIGHPOWER
        |=> ##1 left_path.highpower_path && !left_path.default_path;
    endproperty
    a_left_route: assert property (p_left_route) else $error("left route wrong");

    property p_right_route;
        @(posedge clk) disable iff (rst)
        wr_en && addr == `ROUTING_CTRL_ADDR && wdata[5:4] == `PATH_LINEOUT
        |=> ##1 right_path.lineout_path && !right_path.highpower_path;
    endproperty
    a_right_route: assert property (p_right_route) else $error("right route wrong");

    property p_vol_indep;
        @(posedge clk) disable iff (rst)
        routing_ff.vol_link inside {2'h0, 2'h3} && $stable(routing_ff)
        |=> left_vol_eff == $past(left_vol_reg) && right_vol_eff == $past(right_vol_reg);
    endproperty
    a_vol_indep: assert property (p_vol_indep) else $error("volumes not independent");

    property p_left_follow;
        @(posedge clk) disable iff (rst)
        routing_ff.vol_link == `LINK_LEFT_FOLLOWS |=> left_vol_eff == $past(right_vol_reg);
    endproperty
    a_left_follow: assert property (p_left_follow) else $error("left not following");

    property p_right_follow;
        @(posedge clk) disable iff (rst)
        routing_ff.vol_link == `LINK_RIGHT_FOLLOWS |=> right_vol_eff == $past(left_vol_reg);
    endproperty
    a_right_follow: assert property (p_right_follow) else $error("right not following");

    property p_delay_off;
        @(posedge clk) disable iff (rst)
        state_ff == dac_routing_popreduce_pkg::DRV_DELAY |-> !drv_enable && !drv_ready;
    endproperty
    a_delay_off: assert property (p_delay_off) else $error("driver on during delay");

    property p_delay_load;
        @(posedge clk) disable iff (rst)
        state_ff == dac_routing_popreduce_pkg::DRV_OFF && drv_power_req
        |=> cnt_ff == $past(dly_sel);
    endproperty
    a_delay_load: assert property (p_delay_load) else $error("delay count wrong");

    property p_step_load;
        @(posedge clk) disable iff (rst)
        state_ff == dac_routing_popreduce_pkg::DRV_DELAY && cnt_ff == '0 && drv_power_req
        |=> state_ff == dac_routing_popreduce_pkg::DRV_RAMP && cnt_ff == $past(step_sel);
    endproperty
    a_step_load: assert property (p_step_load) else $error("step count wrong");

    property p_cm_sel;
        @(posedge clk) disable iff (rst)
        wr_en && addr == `POP_CTRL_ADDR |=> ##1 weak_cm_bandgap == $past(wdata[1], 2);
    endproperty
    a_cm_sel: assert property (p_cm_sel) else $error("common-mode select wrong");

    property p_ramp_mono;
        @(posedge clk) disable iff (rst)
        drv_power_req && $past(drv_power_req) |-> drv_ramp_level >= $past(drv_ramp_level);
    endproperty
    a_ramp_mono: assert property (p_ramp_mono) else $error("ramp level fell");

    property p_readback;
        @(posedge clk) disable iff (rst)
        wr_en && addr == `POP_CTRL_ADDR ##1 rd_en && addr == `POP_CTRL_ADDR && !wr_en
        |=> rdata == $past(wdata, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("read-back mismatch");

    c_full_ramp: cover property (@(posedge clk) disable iff (rst) $rose(drv_ready));
    c_left_follow: cover property (@(posedge clk) disable iff (rst)
        routing_ff.vol_link == `LINK_LEFT_FOLLOWS);
    c_abort: cover property (@(posedge clk) disable iff (rst)
        state_ff == dac_routing_popreduce_pkg::DRV_RAMP && !drv_power_req);

endmodule : dac_routing_popreduce_regs

/* verif/dac_routing_popreduce_regs_tb.sv */
// self-checking bench of the routing and pop-reduction bank
`timescale 1ns/1ps
`include "dac_routing_popreduce_regs.svh"
module dac_routing_popreduce_regs_tb;
    // ==========================================================
    // short counts so every delay code fits in the run
    localparam int unsigned DLY [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11};
    localparam int unsigned STP [4]  = '{0, 2, 3, 5};
    localparam int unsigned STEPS    = 8;

    logic                                  clk;
    logic                                  rst;
    logic                                  wr_en;
    logic                                  rd_en;
    logic                                  drv_power_req;
    logic [7:0]                            addr;
    logic [7:0]                            wdata;
    logic [7:0]                            rdata;
    dac_routing_popreduce_pkg::dac_vol_t   left_vol_reg;
    dac_routing_popreduce_pkg::dac_vol_t   right_vol_reg;
    dac_routing_popreduce_pkg::dac_vol_t   left_vol_eff;
    dac_routing_popreduce_pkg::dac_vol_t   right_vol_eff;
    dac_routing_popreduce_pkg::path_sel_t  left_path;
    dac_routing_popreduce_pkg::path_sel_t  right_path;
    logic                                  weak_cm_bandgap;
    logic                                  drv_enable;
    logic                                  drv_ready;
    logic [3:0]                            drv_ramp_level;
    int                                    num_errors;
    int                                    n_tests;
    logic [31:0]                           seed;

    dac_routing_popreduce_regs #(
        .DLY_CYC    (DLY),
        .STEP_CYC   (STP),
        .RAMP_STEPS (STEPS)
    ) i_dut (
        .clk             (clk),
        .rst             (rst),
        .wr_en           (wr_en),
        .rd_en           (rd_en),
        .addr            (addr),
        .wdata           (wdata),
        .rdata           (rdata),
        .left_vol_reg    (left_vol_reg),
        .right_vol_reg   (right_vol_reg),
        .left_vol_eff    (left_vol_eff),
        .right_vol_eff   (right_vol_eff),
        .left_path       (left_path),
        .right_path      (right_path),
        .weak_cm_bandgap (weak_cm_bandgap),
        .drv_power_req   (drv_power_req),
        .drv_enable      (drv_enable),
        .drv_ramp_level  (drv_ramp_level),
        .drv_ready       (drv_ready)
    );

    // ==========================================================
    // clock and helpers
    initial clk = 1'b0;
    always #5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [2:0] exp_path(input logic [1:0] c);
        case (c)
            2'h0: exp_path = 3'h4;
            2'h1: exp_path = 3'h2;
            2'h2: exp_path = 3'h1;
            default: exp_path = 3'h0;
        endcase
    endfunction : exp_path

    // link picks which channel register feeds a side
    function automatic logic [7:0] exp_vol(input logic [1:0] lk, input logic left_side,
                                           input logic [7:0] lv, input logic [7:0] rv);
        if (lk == 2'h1) return rv;
        if (lk == 2'h2) return lv;
        return left_side ? lv : rv;
    endfunction : exp_vol

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // one idle edge first, so a strobe is never lowered and raised in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        chk(what, exp, rdata);
    endtask : rd_chk

    // write, then read the same place at the very next edge
    task automatic wr_rd_chk(input string what, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        chk(what, d, rdata);
    endtask : wr_rd_chk

    // power-up: delay count, then ramp steps, then power down by dropping the request once ready
    task automatic seq(input logic [3:0] dc, input logic [1:0] sc);
        int n;
        wr(`POP_CTRL_ADDR, {dc, sc, 2'b00});
        drv_power_req = 1'b1;
        n = 0;
        while (drv_enable !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("enable delay", DLY[dc] + 2, n);
        chk("ramp start level", 4'h0, drv_ramp_level);
        n = 0;
        while (drv_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("ramp time", STEPS * (STP[sc] + 1), n);
        chk("ramp end level", STEPS, drv_ramp_level);
        drv_power_req = 1'b0;
        @(negedge clk);
        chk("off after drop", 3'h0, {drv_enable, drv_ready, drv_ramp_level != 4'h0});
    endtask : seq

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // watchdog, well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] t;
        logic [7:0]  v;
        num_errors = 0;
        n_tests = 0;
        seed = 32'h0DA4;
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        left_vol_reg = 8'h00;
        right_vol_reg = 8'h00;
        drv_power_req = 1'b0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        rd_chk("routing reset", `ROUTING_CTRL_ADDR, 8'h00);
        rd_chk("pop reset", `POP_CTRL_ADDR, 8'h00);
        chk("left path reset", 3'h4, left_path);
        chk("right path reset", 3'h4, right_path);
        // every defined route code (not reserved 11) and every link code, random volumes including mute
        for (int i = 0; i < 12; i++) begin
            t = rnd();
            left_vol_reg = t[7:0];
            right_vol_reg = t[15:8];
            v = {2'(i % 3), 2'((i + 1) % 3), 2'b00, 2'(i / 3)};
            wr(`ROUTING_CTRL_ADDR, v);
            @(negedge clk);
            chk("left path", exp_path(v[7:6]), left_path);
            chk("right path", exp_path(v[5:4]), right_path);
            chk("left vol", exp_vol(v[1:0], 1'b1, t[7:0], t[15:8]), left_vol_eff);
            chk("right vol", exp_vol(v[1:0], 1'b0, t[7:0], t[15:8]), right_vol_eff);
            rd_chk("routing readback", `ROUTING_CTRL_ADDR, v);
        end
        // unmapped place: ignored on write, zero on read
        wr(8'h2B, 8'hFF);
        rd_chk("unmapped read", 8'h2B, `UNMAPPED_RDATA);
        rd_chk("routing kept", `ROUTING_CTRL_ADDR, v);
        // pop register fields with random legal codes
        for (int i = 0; i < 8; i++) begin
            t = rnd();
            v = {4'(t[3:0] % 12), t[5:4], t[6], 1'b0};
            wr_rd_chk("pop readback", `POP_CTRL_ADDR, v);
            chk("weak cm source", v[1], weak_cm_bandgap);
        end
        // every defined delay code (0 to 11), every step code
        for (int i = 0; i < 12; i++) begin
            seq(4'(i), 2'(i % 4));
        end
        // abort in mid-delay keeps the driver off
        wr(`POP_CTRL_ADDR, 8'hB0);
        drv_power_req = 1'b1;
        repeat (6) @(negedge clk);
        chk("held off in delay", 1'b0, drv_enable);
        drv_power_req = 1'b0;
        repeat (20) @(negedge clk);
        chk("aborted stays off", 1'b0, drv_enable);
        // reset in mid-ramp clears the bank and the sequencer
        wr(`ROUTING_CTRL_ADDR, 8'h61);
        drv_power_req = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b1;
        drv_power_req = 1'b0;
        repeat (2) @(negedge clk);
        chk("driver in reset", 3'h0, {drv_enable, drv_ready, drv_ramp_level != 4'h0});
        rst = 1'b0;
        rd_chk("routing after reset", `ROUTING_CTRL_ADDR, 8'h00);
        rd_chk("pop after reset", `POP_CTRL_ADDR, 8'h00);
        wrap_up();
    end
endmodule : dac_routing_popreduce_regs_tb
